// File: rtl/acc_edge_detect.sv
// Purpose: Synchronise the comparator result and find its edges.
// Assumes: Raw comparator output is asynchronous to pclk.
// Notes: Output lags the raw input by one to two clocks.
`timescale 1ns/1ps
`default_nettype none
module acc_edge_detect (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic raw_in,
   input wire acc_pkg::acc_mode_t mode,
   output logic sync_out,
   output logic event_pulse
);
   import acc_pkg::*;

   logic meta_r;
   logic sync_r;
   logic prev_r;

   // The first stage feeds only the second stage.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else begin
         meta_r <= raw_in;
         sync_r <= meta_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= sync_r;
      end
   end

   assign sync_out = sync_r;

   always_comb begin
      case (mode)
         ACC_MODE_TOGGLE: event_pulse = sync_r ^ prev_r;
         ACC_MODE_FALL: event_pulse = prev_r & ~sync_r;
         ACC_MODE_RISE: event_pulse = sync_r & ~prev_r;
         default: event_pulse = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// File: rtl/acc_pkg.sv
// Purpose: Shared constants and types for the comparator control block.
// Assumes: APB with 32-bit data; each register in one aligned word.
// Notes: Register byte offsets are local choices.
package acc_pkg;
   localparam logic [11:0] ACC_OFF_CONV_B = 12'h000;
   localparam logic [11:0] ACC_OFF_CTRL_STATUS = 12'h004;
   localparam logic [11:0] ACC_OFF_DIN_DISABLE = 12'h008;
   localparam logic [11:0] ACC_OFF_CONV_CTRL = 12'h00C;

   // Field positions in converter_control_b.
   localparam int ACC_B_MUX_EN = 6;
   localparam int ACC_B_DIV_HI = 5;
   localparam int ACC_B_DIV_LO = 4;
   localparam logic [7:0] ACC_B_WMASK = 8'h77;

   // Field positions in comparator_control_status.
   localparam int ACC_S_POWER_OFF = 7;
   localparam int ACC_S_IREF_SEL = 6;
   localparam int ACC_S_OUTPUT = 5;
   localparam int ACC_S_FLAG = 4;
   localparam int ACC_S_IRQ_EN = 3;
   localparam int ACC_S_CAPTURE = 2;
   localparam int ACC_S_MODE_HI = 1;
   localparam int ACC_S_MODE_LO = 0;

   // Field positions in digital_input_disable_0.
   localparam int ACC_D_POS_OFF = 7;
   localparam int ACC_D_NEG_OFF = 6;

   // Field positions in the converter control register of own choice.
   localparam int ACC_C_CONV_EN = 7;
   localparam int ACC_C_SRC_HI = 6;
   localparam int ACC_C_CHAN_HI = 4;
   // Converter enable, the two reference source bits and the channel code
   // are all writable, so source code 11 can be reached.
   localparam logic [7:0] ACC_C_WMASK = 8'hFF;

   localparam logic [7:0] ACC_RESET_BYTE = 8'h00;
   localparam logic [4:0] ACC_CHAN_LAST = 5'h0A;
   localparam logic [4:0] ACC_CHAN_CURRENT_SOURCE_CHANNEL = 5'h03;
   localparam logic [1:0] ACC_REF_SRC_INTERNAL = 2'h3;
   localparam int ACC_SYNC_STAGES = 2;

   typedef enum logic [1:0] {
      ACC_MODE_TOGGLE = 2'h0,
      ACC_MODE_RSVD = 2'h1,
      ACC_MODE_FALL = 2'h2,
      ACC_MODE_RISE = 2'h3
   } acc_mode_t;

   // Analogue steering toward the comparator front end.
   typedef struct packed {
      logic power_off;
      logic pos_from_mux;
      logic [4:0] pos_channel;
      logic pos_current_source_channel_shared;
      logic neg_from_ref;
      logic ref_valid;
      logic [1:0] ref_division;
   } acc_analog_t;
endpackage

// File: rtl/acc_top.sv
// Purpose: Register, steering and event logic of the comparator.
// Assumes: APB slave, one clock; comparator and pins sit outside.
// Notes: Irq enable and vector entry come from the core.
`timescale 1ns/1ps
`default_nettype none
module acc_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic comparator_raw,
   input wire logic positive_pin_in,
   input wire logic negative_pin_in,
   input wire logic global_irq_enable,
   input wire logic irq_vector_ack,
   output logic irq_request,
   output logic capture_input,
   output logic capture_route_enable,
   output logic positive_pin_read,
   output logic negative_pin_read,
   output logic positive_pin_buffer_off,
   output logic negative_pin_buffer_off,
   output acc_pkg::acc_analog_t analog_ctrl
);
   import acc_pkg::*;

   logic [7:0] conv_b_r;
   logic [7:0] status_ctrl_r;
   logic [7:0] din_dis_r;
   logic [7:0] conv_ctrl_r;
   logic flag_r;
   logic irq_r;
   logic cap_r;
   logic cap_en_r;
   logic pos_read_r;
   logic neg_read_r;
   logic pos_off_r;
   logic neg_off_r;
   acc_analog_t analog_r;
   acc_analog_t analog_nxt;
   logic [31:0] prdata_r;
   logic pslverr_r;
   logic sync_out;
   logic event_pulse;
   logic access;
   logic wr;
   logic hit;
   logic [7:0] wbyte;
   logic [7:0] status_view;
   acc_mode_t mode;

   assign access = psel & penable;
   assign wr = access & pwrite;
   assign wbyte = pwdata[7:0];
   assign hit = (paddr == ACC_OFF_CONV_B) || (paddr == ACC_OFF_CTRL_STATUS)
      || (paddr == ACC_OFF_DIN_DISABLE) || (paddr == ACC_OFF_CONV_CTRL);
   assign mode = acc_mode_t'(status_ctrl_r[ACC_S_MODE_HI:ACC_S_MODE_LO]);

   acc_edge_detect u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .raw_in(comparator_raw),
      .mode(mode),
      .sync_out(sync_out),
      .event_pulse(event_pulse)
   );

   // Control registers; writable bits clear on reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_b_r <= ACC_RESET_BYTE;
         status_ctrl_r <= ACC_RESET_BYTE;
         din_dis_r <= ACC_RESET_BYTE;
         conv_ctrl_r <= ACC_RESET_BYTE;
      end else if (wr) begin
         case (paddr)
            ACC_OFF_CONV_B: conv_b_r <= wbyte & ACC_B_WMASK;
            // Output and flag bits live elsewhere; keep them zero here.
            ACC_OFF_CTRL_STATUS: status_ctrl_r <= wbyte & 8'hCF;
            ACC_OFF_DIN_DISABLE: din_dis_r <= wbyte;
            ACC_OFF_CONV_CTRL: conv_ctrl_r <= wbyte & ACC_C_WMASK;
            default: ;
         endcase
      end
   end

   // Set wins over both software clear and vector clear, so no event
   // is lost in the cycle it is being cleared.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_r <= 1'b0;
      end else if (event_pulse) begin
         flag_r <= 1'b1;
      end else if (irq_vector_ack) begin
         flag_r <= 1'b0;
      end else if (wr && paddr == ACC_OFF_CTRL_STATUS && wbyte[ACC_S_FLAG]) begin
         flag_r <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= flag_r & status_ctrl_r[ACC_S_IRQ_EN]
            & global_irq_enable;
      end
   end

   // Timer filter and edge select follow outside; this only gates.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_r <= 1'b0;
         cap_en_r <= 1'b0;
      end else begin
         cap_en_r <= status_ctrl_r[ACC_S_CAPTURE];
         cap_r <= status_ctrl_r[ACC_S_CAPTURE] & sync_out;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos_read_r <= 1'b0;
         neg_read_r <= 1'b0;
         pos_off_r <= 1'b0;
         neg_off_r <= 1'b0;
      end else begin
         pos_off_r <= din_dis_r[ACC_D_POS_OFF];
         neg_off_r <= din_dis_r[ACC_D_NEG_OFF];
         pos_read_r <= positive_pin_in & ~din_dis_r[ACC_D_POS_OFF];
         neg_read_r <= negative_pin_in & ~din_dis_r[ACC_D_NEG_OFF];
      end
   end

   always_comb begin
      analog_nxt = '0;
      analog_nxt.power_off = status_ctrl_r[ACC_S_POWER_OFF];
      analog_nxt.pos_from_mux = conv_b_r[ACC_B_MUX_EN]
         & ~conv_ctrl_r[ACC_C_CONV_EN]
         & (conv_ctrl_r[ACC_C_CHAN_HI:0] <= ACC_CHAN_LAST);
      analog_nxt.pos_channel = conv_ctrl_r[ACC_C_CHAN_HI:0];
      // The shared current-source channel matters only while multiplexed.
      analog_nxt.pos_current_source_channel_shared = analog_nxt.pos_from_mux
         & (conv_ctrl_r[ACC_C_CHAN_HI:0] == ACC_CHAN_CURRENT_SOURCE_CHANNEL);
      analog_nxt.neg_from_ref = status_ctrl_r[ACC_S_IREF_SEL];
      analog_nxt.ref_valid = status_ctrl_r[ACC_S_IREF_SEL]
         & (conv_ctrl_r[ACC_C_SRC_HI -: 2] == ACC_REF_SRC_INTERNAL);
      analog_nxt.ref_division = conv_b_r[ACC_B_DIV_HI:ACC_B_DIV_LO];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         analog_r <= '0;
      end else begin
         analog_r <= analog_nxt;
      end
   end

   always_comb begin
      status_view = status_ctrl_r;
      status_view[ACC_S_OUTPUT] = sync_out;
      status_view[ACC_S_FLAG] = flag_r;
   end

   // Read data is registered in the setup cycle, so every access
   // completes with zero wait states.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (psel && !penable) begin
         pslverr_r <= !hit;
         case (paddr)
            ACC_OFF_CONV_B: prdata_r <= {24'h000000, conv_b_r};
            ACC_OFF_CTRL_STATUS: prdata_r <= {24'h000000, status_view};
            ACC_OFF_DIN_DISABLE: prdata_r <= {24'h000000, din_dis_r};
            ACC_OFF_CONV_CTRL: prdata_r <= {24'h000000, conv_ctrl_r};
            default: prdata_r <= 32'h0000_0000;
         endcase
      end
   end

   assign prdata = prdata_r;
   assign pslverr = pslverr_r;
   assign pready = 1'b1;
   assign irq_request = irq_r;
   assign capture_input = cap_r;
   assign capture_route_enable = cap_en_r;
   assign positive_pin_read = pos_read_r;
   assign negative_pin_read = neg_read_r;
   assign positive_pin_buffer_off = pos_off_r;
   assign negative_pin_buffer_off = neg_off_r;
   assign analog_ctrl = analog_r;
endmodule
`default_nettype wire

// File: sim/acc_far_model.sv
// Purpose: Comparator and core stand-in for the bench.
// Assumes: The bench sets the comparison result.
// Notes: Vector entry is prompt or three clocks late.
`timescale 1ns/1ps
`default_nettype none
module acc_far_model (
   input wire logic pclk,
   input wire logic level,
   input wire logic ack_on,
   input wire logic slow,
   input wire acc_pkg::acc_analog_t analog_ctrl,
   input wire logic irq_request,
   output logic comparator_raw,
   output logic irq_vector_ack = 1'b0
);
   logic [2:0] wait_r = 3'h0;
   // A powered-down comparator holds its result low.
   assign comparator_raw = level & ~analog_ctrl.power_off;
   // One vector entry per request, so the flag is not cleared twice.
   always @(posedge pclk) begin
      irq_vector_ack <= 1'b0;
      if (!irq_request || !ack_on) begin
         wait_r <= 3'h0;
      end else if (wait_r == (slow ? 3'h3 : 3'h0)) begin
         irq_vector_ack <= 1'b1;
         wait_r <= 3'h7;
      end else if (wait_r != 3'h7) begin
         wait_r <= wait_r + 3'h1;
      end
   end
endmodule
`default_nettype wire

// File: sim/acc_top_sva.sv
// Purpose: Port checks of the comparator control block.
// Assumes: One clock domain, bound to acc_top.
// Notes: The flag itself is judged by the bench.
`timescale 1ns/1ps
`default_nettype none
module acc_top_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic comparator_raw,
   input wire logic global_irq_enable,
   input wire logic positive_pin_in,
   input wire logic negative_pin_in,
   input wire logic irq_request,
   input wire logic capture_input,
   input wire logic capture_route_enable,
   input wire logic positive_pin_read,
   input wire logic negative_pin_read,
   input wire logic positive_pin_buffer_off,
   input wire logic negative_pin_buffer_off,
   input wire acc_pkg::acc_analog_t analog_ctrl
);
   import acc_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence rd_access;
      psel && penable && !pwrite;
   endsequence
   sequence raw_steady;
      (capture_route_enable && $stable(comparator_raw)) [*4];
   endsequence
   irq_global_a: assert property (
      irq_request |-> $past(global_irq_enable)) else $error("irq no gie");
   cap_route_a: assert property (
      capture_input |-> capture_route_enable) else $error("cap unrouted");
   cap_follow_a: assert property (
      raw_steady |-> capture_input == comparator_raw) else $error("cap lag");
   pos_off_a: assert property (
      positive_pin_buffer_off |-> !positive_pin_read) else $error("pos pin");
   neg_off_a: assert property (
      negative_pin_buffer_off |-> !negative_pin_read) else $error("neg pin");
   mux_range_a: assert property (
      analog_ctrl.pos_from_mux |-> analog_ctrl.pos_channel <= ACC_CHAN_LAST)
      else $error("bad channel");
   unmapped_a: assert property (
      rd_access ##0 (paddr > ACC_OFF_CONV_CTRL) |-> pslverr && prdata == 0)
      else $error("unmapped read");
   upper_zero_a: assert property (
      rd_access |-> prdata[31:8] == 24'h0) else $error("upper bits");
   pos_read_a: assert property (
      $past(presetn) |-> positive_pin_read ==
      ($past(positive_pin_in) && !positive_pin_buffer_off))
      else $error("pos pin level");
   neg_read_a: assert property (
      $past(presetn) |-> negative_pin_read ==
      ($past(negative_pin_in) && !negative_pin_buffer_off))
      else $error("neg pin level");
endmodule
bind acc_top acc_top_chk u_chk (.*);
`default_nettype wire

// File: sim/testbench.sv
// Purpose: Random and corner tests of the comparator block.
// Assumes: Zero-wait APB slave with registered outputs.
// Notes: Flag state is seen through status reads.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import acc_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, lvl = 1'b0, gie = 1'b0, ack_on = 1'b0, slow = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, raw, ack, irq, cap, cap_en;
   logic [1:0] pins = 2'h0;
   acc_analog_t an, g;
   int failures = 0, check_count = 0, cyc = 0;
   logic [7:0] w [4];
   localparam logic [7:0] MASK [4] = '{8'h77, 8'hCF, 8'hFF, 8'hFF};
   initial forever #5 pclk = ~pclk;
   acc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .comparator_raw(raw), .positive_pin_in(pins[1]),
      .negative_pin_in(pins[0]), .global_irq_enable(gie),
      .irq_vector_ack(ack), .irq_request(irq), .capture_input(cap),
      .capture_route_enable(cap_en), .positive_pin_read(),
      .negative_pin_read(), .positive_pin_buffer_off(),
      .negative_pin_buffer_off(), .analog_ctrl(an));
   acc_far_model FAR (.pclk(pclk), .level(lvl), .ack_on(ack_on),
      .slow(slow), .analog_ctrl(an), .irq_request(irq),
      .comparator_raw(raw), .irq_vector_ack(ack));
   always @(posedge pclk) begin
      pins <= 2'($urandom);
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         failures++;
         tally_and_finish();
      end
   end
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic acc_analog_t exp_an(logic [7:0] b, s, c);
      logic mux;
      mux = b[6] && !c[7] && c[4:0] <= ACC_CHAN_LAST;
      return {s[7], mux, mux ? c[4:0] : 5'h0, mux && c[4:0] == ACC_CHAN_CURRENT_SOURCE_CHANNEL,
         s[6], s[6] && c[6:5] == ACC_REF_SRC_INTERNAL,
         s[6] ? b[5:4] : 2'h0};
   endfunction
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      void'($urandom(32'h803e6b61));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, 12'(4 * i), 8'h00);
         chk(rd, 32'h0);
         chk(32'(pslverr), 32'(i == 4));
      end
      for (int k = 0; k < 8; k++) begin
         foreach (w[i]) w[i] = 8'($urandom);
         w[1] &= 8'hE7;
         if (k < 2) w[3] = 8'h0A + 8'(k);
         if (k < 2) w[0][6] = 1'b1;
         foreach (w[i]) apb(1'b1, 12'(4 * i), w[i]);
         foreach (w[i]) begin
            apb(1'b0, 12'(4 * i), 8'h00);
            chk(rd, 32'(w[i] & MASK[i]));
         end
         g = an;
         if (!g.pos_from_mux) g.pos_channel = 5'h00;
         if (!g.neg_from_ref) g.ref_division = 2'h0;
         chk(32'(g), 32'(exp_an(w[0] & MASK[0], w[1], w[3] & MASK[3])));
      end
      $display("register test done");
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, ACC_OFF_CTRL_STATUS, 8'h10 | 8'(m));
         lvl <= 1'b1;
         repeat (4) @(posedge pclk);
         apb(1'b0, ACC_OFF_CTRL_STATUS, 8'h00);
         chk(32'(rd[5:4]), 32'({1'b1, m == 0 || m == 3}));
         apb(1'b1, ACC_OFF_CTRL_STATUS, 8'(m));
         lvl <= 1'b0;
         repeat (4) @(posedge pclk);
         apb(1'b0, ACC_OFF_CTRL_STATUS, 8'h00);
         chk(32'(rd[5:4]), 32'(m != 1));
         apb(1'b1, ACC_OFF_CTRL_STATUS, 8'h10 | 8'(m));
         apb(1'b0, ACC_OFF_CTRL_STATUS, 8'h00);
         chk(32'(rd[4]), 32'h0);
      end
      $display("event test done");
      apb(1'b1, ACC_OFF_CTRL_STATUS, 8'h13);
      apb(1'b1, ACC_OFF_CTRL_STATUS, 8'h0B);
      slow <= 1'($urandom);
      ack_on <= 1'b1;
      lvl <= 1'b1;
      repeat (6) @(posedge pclk);
      chk(32'(irq), 32'h0);
      gie <= 1'b1;
      for (int t = 0; t < 20 && ack !== 1'b1; t++) @(posedge pclk);
      chk(32'(ack), 32'h1);
      repeat (3) @(posedge pclk);
      chk(32'(irq), 32'h0);
      apb(1'b0, ACC_OFF_CTRL_STATUS, 8'h00);
      chk(32'(rd[4]), 32'h0);
      $display("interrupt test done");
      apb(1'b1, ACC_OFF_CTRL_STATUS, 8'h03);
      apb(1'b1, ACC_OFF_CTRL_STATUS, 8'h04);
      repeat (4) begin
         lvl <= 1'($urandom);
         repeat (4) @(posedge pclk);
         chk(32'(cap), 32'(lvl));
      end
      apb(1'b1, ACC_OFF_CTRL_STATUS, 8'h00);
      repeat (3) @(posedge pclk);
      chk(32'(cap), 32'h0);
      $display("capture test done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
